/* rtl/prtm_defs.svh */
`ifndef PRTM_DEFS_SVH
`define PRTM_DEFS_SVH
// =====================================================================
// register offsets (byte addresses)
`define PRTM_OFF_CNT 8'h00
`define PRTM_OFF_PER 8'h04
`define PRTM_OFF_CTL 8'h08
`define PRTM_TMR_STRIDE 8'h10
`define PRTM_OFF_SEL 8'h30
`define PRTM_OFF_FLAG 8'h34
`define PRTM_OFF_IEN 8'h38
// =====================================================================
// control field positions
`define PRTM_CTL_POST_MSB 6
`define PRTM_CTL_POST_LSB 3
`define PRTM_CTL_RUN_BIT 2
`define PRTM_CTL_PRE_MSB 1
`define PRTM_CTL_PRE_LSB 0
// =====================================================================
// reset values
`define PRTM_COUNT_RST 8'h00
`define PRTM_PERIOD_RST 8'hff
`define PRTM_CTL_RST 7'h00
`define PRTM_SEL_RST 8'h00
`define PRTM_FLAG_RST 3'h0
// =====================================================================
// timing: instruction clock is pclk divided by four
`define PRTM_INSTR_DIV_LAST 2'h3
// prescaler terminal counts for divide by 1, 4, 16, 64
`define PRTM_PRE_LAST_1 6'h00
`define PRTM_PRE_LAST_4 6'h03
`define PRTM_PRE_LAST_16 6'h0f
`define PRTM_PRE_LAST_64 6'h3f
`endif

/* rtl/prtm_pkg.sv */
package prtm_pkg;
   // ==================================================================
   // types
   typedef enum logic [1:0] {
      PRTM_TB_FIRST,
      PRTM_TB_SECOND,
      PRTM_TB_THIRD,
      PRTM_TB_RESERVED
   } prtm_tb_choice_t;

   typedef struct packed {
      logic run;
      logic [1:0] pre_sel;
      logic [3:0] post_sel;
      logic cnt_wr;
      logic per_wr;
      logic ctl_wr;
      logic [7:0] wdata;
   } prtm_tmr_ctl_t;

   typedef struct packed {
      logic [7:0] count;
      logic [7:0] period;
      logic [5:0] pre_cnt;
      logic [3:0] post_cnt;
      logic match;
      logic post_evt;
   } prtm_tmr_state_t;

   typedef struct packed {
      logic [1:0] div;
      logic [2:0][6:0] ctl;
      logic [7:0] sel;
      logic [2:0] flags;
      logic [2:0] irq_en;
      logic [31:0] prdata;
      logic pslverr;
      logic spi_clk;
   } prtm_top_state_t;
endpackage : prtm_pkg

/* rtl/prtm_timer.sv */
`include "prtm_defs.svh"
module prtm_timer import prtm_pkg::*; (
   input wire logic pclk,
   input wire logic presetn,
   input wire logic tick,
   input wire logic sleep,
   input prtm_tmr_ctl_t ctl,
   output logic [7:0] count,
   output logic [7:0] period,
   output logic match,
   output logic post_evt
);
   prtm_tmr_state_t s_r;
   prtm_tmr_state_t s_nxt;
   logic adv;

   function automatic logic [5:0] pre_last(input logic [1:0] sel);
      case (sel)
         2'h0: pre_last = `PRTM_PRE_LAST_1;
         2'h1: pre_last = `PRTM_PRE_LAST_4;
         2'h2: pre_last = `PRTM_PRE_LAST_16;
         default: pre_last = `PRTM_PRE_LAST_64;
      endcase
   endfunction : pre_last

   // ==================================================================
   // prescaler, period counter, postscaler
   always_comb begin
      s_nxt = s_r;
      adv = 1'b0;
      s_nxt.match = 1'b0;
      s_nxt.post_evt = 1'b0;
      // counts only on instruction ticks, never while asleep
      if (tick && ctl.run && !sleep) begin
         if (s_r.pre_cnt >= pre_last(ctl.pre_sel)) begin
            s_nxt.pre_cnt = 6'h00;
            adv = 1'b1;
         end else begin
            s_nxt.pre_cnt = 6'(s_r.pre_cnt + 6'h01);
         end
      end
      if (adv) begin
         if (s_r.count == s_r.period) begin
            s_nxt.count = 8'h00;
            s_nxt.match = 1'b1;
            if (s_r.post_cnt >= ctl.post_sel) begin
               s_nxt.post_cnt = 4'h0;
               s_nxt.post_evt = 1'b1;
            end else begin
               s_nxt.post_cnt = 4'(s_r.post_cnt + 4'h1);
            end
         end else begin
            s_nxt.count = 8'(s_r.count + 8'h01);
         end
      end
      if (ctl.per_wr) begin
         s_nxt.period = ctl.wdata;
      end
      if (ctl.cnt_wr) begin
         s_nxt.count = ctl.wdata;
      end
      // control write keeps the count itself
      if (ctl.cnt_wr || ctl.ctl_wr) begin
         s_nxt.pre_cnt = 6'h00;
         s_nxt.post_cnt = 4'h0;
      end
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         s_r.count <= `PRTM_COUNT_RST;
         s_r.period <= `PRTM_PERIOD_RST;
         s_r.pre_cnt <= 6'h00;
         s_r.post_cnt <= 4'h0;
         s_r.match <= 1'b0;
         s_r.post_evt <= 1'b0;
      end else begin
         s_r <= s_nxt;
      end
   end

   assign count = s_r.count;
   assign period = s_r.period;
   assign match = s_r.match;
   assign post_evt = s_r.post_evt;
endmodule : prtm_timer

/* rtl/prtm_top.sv */
// Operation
// - counter clocked by instruction clock via prescaler
// - match emits pulse, counter reloads to zero
// - reset clears counter, period set to ones
// - counter/control write clears pre/postscaler counts
// - match pulses feed four-bit postscaler to interrupt
// - postscaler output sets latched match flag
// - flag raises interrupt only when enabled
// - postscale field bits 6-3 divide by code+1
// - raw match drives PWM time base outputs
// - timer output offered as SPI shift clock
// - no counting during sleep, registers hold
// - control bit 2 runs or halts timer
// - prescale bits 1-0 divide 1/4/16/64
// - three identical 8-bit auto-reload timers
// - each PWM unit picks its timer independently
// - select fields 7-6,5-4,3-2,1-0 per unit
// - choice 00/01/10 pick timer, 11 reserved
`include "prtm_defs.svh"
module prtm_top import prtm_pkg::*; #(
   parameter int ADDR_W = 12
) (
   input wire logic pclk,
   input wire logic presetn,
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [ADDR_W-1:0] paddr,
   input wire logic [31:0] pwdata,
   output logic [31:0] prdata,
   output logic pready,
   output logic pslverr,
   input wire logic sleep,
   output logic [2:0] timer_match,
   output logic [3:0] unit_timebase,
   output logic spi_shift_clk,
   output logic irq
);
   localparam int NTMR = 3;
   localparam int NUNIT = 4;

   prtm_top_state_t s_r;
   prtm_top_state_t s_nxt;
   prtm_tmr_ctl_t [NTMR-1:0] tctl;
   logic [NTMR-1:0][7:0] t_count;
   logic [NTMR-1:0][7:0] t_period;
   logic [NTMR-1:0] t_match;
   logic [NTMR-1:0] t_evt;
   logic tick;
   logic setup;
   logic access;
   logic [31:0] rd_word;
   logic rd_hit;
   logic [2:0] rd_clear;

   // ==================================================================
   // address helpers
   function automatic logic addr_is(input logic [ADDR_W-1:0] a,
                                    input logic [7:0] off);
      addr_is = (a == ADDR_W'(off));
   endfunction : addr_is

   function automatic logic [7:0] tmr_off(input int i,
                                          input logic [7:0] off);
      tmr_off = 8'(i * `PRTM_TMR_STRIDE) + off;
   endfunction : tmr_off

   // ==================================================================
   // three timer instances
   genvar gi;
   generate
      for (gi = 0; gi < NTMR; gi++) begin : g_tmr
         prtm_timer u_tmr (
            .pclk(pclk),
            .presetn(presetn),
            .tick(tick),
            .sleep(sleep),
            .ctl(tctl[gi]),
            .count(t_count[gi]),
            .period(t_period[gi]),
            .match(t_match[gi]),
            .post_evt(t_evt[gi])
         );
      end
   endgenerate

   assign tick = (s_r.div == `PRTM_INSTR_DIV_LAST);
   assign setup = psel && !penable;
   assign access = psel && penable;

   // ==================================================================
   // read mux
   always_comb begin
      rd_word = 32'h0000_0000;
      rd_hit = 1'b0;
      for (int i = 0; i < NTMR; i++) begin
         if (addr_is(paddr, tmr_off(i, `PRTM_OFF_CNT))) begin
            rd_word = {24'h00_0000, t_count[i]};
            rd_hit = 1'b1;
         end
         if (addr_is(paddr, tmr_off(i, `PRTM_OFF_PER))) begin
            rd_word = {24'h00_0000, t_period[i]};
            rd_hit = 1'b1;
         end
         if (addr_is(paddr, tmr_off(i, `PRTM_OFF_CTL))) begin
            rd_word = {25'h000_0000, s_r.ctl[i]};
            rd_hit = 1'b1;
         end
      end
      if (addr_is(paddr, `PRTM_OFF_SEL)) begin
         rd_word = {24'h00_0000, s_r.sel};
         rd_hit = 1'b1;
      end
      if (addr_is(paddr, `PRTM_OFF_FLAG)) begin
         rd_word = {29'h0000_0000, s_r.flags};
         rd_hit = 1'b1;
      end
      if (addr_is(paddr, `PRTM_OFF_IEN)) begin
         rd_word = {29'h0000_0000, s_r.irq_en};
         rd_hit = 1'b1;
      end
   end

   // ==================================================================
   // bus slave, control registers, interrupt flags
   always_comb begin
      s_nxt = s_r;
      rd_clear = 3'h0;
      s_nxt.div = 2'(s_r.div + 2'h1);
      for (int i = 0; i < NTMR; i++) begin
         tctl[i].run = s_r.ctl[i][`PRTM_CTL_RUN_BIT];
         tctl[i].pre_sel =
            s_r.ctl[i][`PRTM_CTL_PRE_MSB:`PRTM_CTL_PRE_LSB];
         tctl[i].post_sel =
            s_r.ctl[i][`PRTM_CTL_POST_MSB:`PRTM_CTL_POST_LSB];
         tctl[i].cnt_wr = 1'b0;
         tctl[i].per_wr = 1'b0;
         tctl[i].ctl_wr = 1'b0;
         tctl[i].wdata = pwdata[7:0];
      end
      // read data and error captured in setup, answered in access
      if (setup) begin
         s_nxt.prdata = pwrite ? 32'h0000_0000 : rd_word;
         s_nxt.pslverr = !rd_hit;
      end
      if (access && pwrite && rd_hit) begin
         for (int i = 0; i < NTMR; i++) begin
            if (addr_is(paddr, tmr_off(i, `PRTM_OFF_CNT))) begin
               tctl[i].cnt_wr = 1'b1;
            end
            if (addr_is(paddr, tmr_off(i, `PRTM_OFF_PER))) begin
               tctl[i].per_wr = 1'b1;
            end
            if (addr_is(paddr, tmr_off(i, `PRTM_OFF_CTL))) begin
               s_nxt.ctl[i] = pwdata[6:0];
               tctl[i].ctl_wr = 1'b1;
            end
         end
         if (addr_is(paddr, `PRTM_OFF_SEL)) begin
            s_nxt.sel = pwdata[7:0];
         end
         if (addr_is(paddr, `PRTM_OFF_IEN)) begin
            s_nxt.irq_en = pwdata[2:0];
         end
      end
      // a read clears only the bits it returned
      if (access && !pwrite && addr_is(paddr, `PRTM_OFF_FLAG)) begin
         rd_clear = s_r.prdata[2:0];
      end
      // new event beats a clear in the same cycle
      s_nxt.flags = (s_r.flags & ~rd_clear) | t_evt;
      if (t_match[0]) begin
         s_nxt.spi_clk = !s_r.spi_clk;
      end
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         s_r.div <= 2'h0;
         s_r.ctl <= {NTMR{`PRTM_CTL_RST}};
         s_r.sel <= `PRTM_SEL_RST;
         s_r.flags <= `PRTM_FLAG_RST;
         s_r.irq_en <= 3'h0;
         s_r.prdata <= 32'h0000_0000;
         s_r.pslverr <= 1'b0;
         s_r.spi_clk <= 1'b0;
      end else begin
         s_r <= s_nxt;
      end
   end

   // ==================================================================
   // per-unit time base selection
   always_comb begin
      for (int u = 0; u < NUNIT; u++) begin
         case (prtm_tb_choice_t'(s_r.sel[2*u +: 2]))
            PRTM_TB_FIRST: unit_timebase[u] = t_match[0];
            PRTM_TB_SECOND: unit_timebase[u] = t_match[1];
            PRTM_TB_THIRD: unit_timebase[u] = t_match[2];
            default: unit_timebase[u] = 1'b0;
         endcase
      end
   end

   assign timer_match = t_match;
   assign spi_shift_clk = s_r.spi_clk;
   assign irq = |(s_r.flags & s_r.irq_en);
   assign pready = access;
   assign prdata = s_r.prdata;
   assign pslverr = access && s_r.pslverr;
endmodule : prtm_top

/* verification/prtm_assertions.sv */
module prtm_checker import prtm_pkg::*; #(
   parameter int ADDR_W = 12
) (
   input wire logic pclk,
   input wire logic presetn,
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [ADDR_W-1:0] paddr,
   input wire logic [31:0] prdata,
   input wire logic pready,
   input wire logic pslverr,
   input wire logic sleep,
   input wire logic [2:0] timer_match,
   input wire logic [3:0] unit_timebase,
   input wire logic spi_shift_clk,
   input wire logic irq
);
   // ======
   // helpers
   logic acc;
   logic mapped;
   logic ien_wr;
   assign acc = psel && penable;
   assign mapped = paddr[1:0] == 2'h0 && paddr[ADDR_W-1:6] == '0
      && paddr[3:2] != 2'h3;
   assign ien_wr = acc && pwrite && paddr == ADDR_W'(8'h38);
   default clocking @(posedge pclk); endclocking
   default disable iff (!presetn);
   // ======
   // checks
   AST_READY: assert property (pready == acc)
      else $error("ready not zero wait");
   AST_ERR_DECODE: assert property (acc |-> pslverr == !mapped)
      else $error("slave error decode wrong");
   AST_ERR_ONLY_ACC: assert property (pslverr |-> acc)
      else $error("slave error outside access");
   AST_RDATA_HOLD: assert property ($changed(prdata) |->
      $past(psel && !penable)) else $error("read data moved");
   AST_MATCH_GAP: assert property (timer_match[0] |=>
      !timer_match[0] [*3]) else $error("matches too close");
   AST_TB_SUBSET: assert property (unit_timebase != 4'h0 |->
      timer_match != 3'h0) else $error("time base without match");
   AST_SLEEP: assert property (sleep [*3] |->
      timer_match == 3'h0) else $error("match during sleep");
   AST_SPI: assert property ($changed(spi_shift_clk) |->
      timer_match[0] || $past(timer_match[0]))
      else $error("shift clock moved without match");
   AST_IRQ_CAUSE: assert property ($rose(irq) |->
      $past(|timer_match) || $past(ien_wr) || $past(ien_wr, 2))
      else $error("irq rose without cause");
endmodule : prtm_checker

bind prtm_top prtm_checker #(.ADDR_W(ADDR_W)) u_chk (.pclk(pclk),
   .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
   .paddr(paddr), .prdata(prdata), .pready(pready), .pslverr(pslverr),
   .sleep(sleep), .timer_match(timer_match),
   .unit_timebase(unit_timebase), .spi_shift_clk(spi_shift_clk),
   .irq(irq));

/* verification/prtm_far_units.sv */
module prtm_far_units import prtm_pkg::*; (
   input wire logic pclk,
   input wire logic presetn,
   input wire logic [3:0] unit_timebase,
   input wire logic spi_shift_clk,
   output logic [3:0][7:0] unit_pulses,
   output logic [15:0] spi_edges
);
   // ======
   // pwm units count periods, serial port counts shift edges
   logic spi_q;
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         unit_pulses <= '0;
         spi_edges <= 16'h0000;
         spi_q <= 1'b0;
      end else begin
         for (int u = 0; u < 4; u++) begin
            unit_pulses[u] <= unit_pulses[u] + 8'(unit_timebase[u]);
         end
         spi_q <= spi_shift_clk;
         spi_edges <= spi_edges + 16'(spi_q != spi_shift_clk);
      end
   end
endmodule : prtm_far_units

/* verification/prtm_top_bench.sv */
module prtm_top_bench import prtm_pkg::*;;
   timeunit 1ns;
   timeprecision 1ns;
   logic pclk, presetn, psel, penable, pwrite, pready, pslverr, err;
   logic sleep, spi_shift_clk, irq;
   logic [11:0] paddr;
   logic [31:0] pwdata, prdata, rd, v;
   logic [2:0] timer_match;
   logic [3:0] unit_timebase;
   logic [3:0][7:0] unit_pulses, up0;
   logic [15:0] spi_edges, m0_total;
   logic [7:0] sel_v[2] = '{8'h1d, 8'h89};
   int error_cnt, n_checks, m;
   int mt[3];
   logic [7:0] c;
   prtm_top #(.ADDR_W(12)) dut (.pclk(pclk), .presetn(presetn),
      .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
      .pwdata(pwdata), .prdata(prdata), .pready(pready),
      .pslverr(pslverr), .sleep(sleep), .timer_match(timer_match),
      .unit_timebase(unit_timebase), .spi_shift_clk(spi_shift_clk),
      .irq(irq));
   prtm_far_units far (.pclk(pclk), .presetn(presetn),
      .unit_timebase(unit_timebase), .spi_shift_clk(spi_shift_clk),
      .unit_pulses(unit_pulses), .spi_edges(spi_edges));
   initial begin
      pclk = 1'b0;
      forever #10 pclk = ~pclk;
   end
   always @(posedge pclk) begin
      if (!presetn) begin
         m0_total <= 16'h0;
      end else if (timer_match[0] === 1'b1) begin
         m0_total <= m0_total + 16'h1;
      end
   end
   // ======
   // tasks
   task automatic chk(input string nm, input logic [31:0] e, g);
      n_checks++;
      if (g !== e) begin
         error_cnt++;
         $display("MISMATCH %s exp %h got %h", nm, e, g);
      end
   endtask : chk
   task automatic apb(input logic w, input logic [11:0] a,
         input logic [31:0] d);
      @(posedge pclk);
      psel <= 1'b1;
      pwrite <= w;
      paddr <= a;
      pwdata <= d;
      @(posedge pclk);
      penable <= 1'b1;
      @(posedge pclk);
      while (pready !== 1'b1) @(posedge pclk);
      rd = prdata;
      err = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
   endtask : apb
   task automatic wr(input logic [11:0] a, input logic [31:0] d);
      apb(1'b1, a, d);
   endtask : wr
   task automatic rdchk(input logic [11:0] a, input logic [31:0] e);
      apb(1'b0, a, 32'h0);
      chk($sformatf("reg %h", a), e, rd);
   endtask : rdchk
   task automatic meas(input int t, output int n);
      while (timer_match[t] !== 1'b1) @(posedge pclk);
      @(posedge pclk);
      n = 1;
      while (timer_match[t] !== 1'b1) begin
         @(posedge pclk);
         n++;
      end
   endtask : meas
   task automatic end_sim();
      $display("checks %0d errors %0d", n_checks, error_cnt);
      if (error_cnt == 0 && n_checks > 0) begin
         $display("Test passed");
      end else begin
         $display("Test failed");
      end
      $finish;
   endtask : end_sim
   initial begin
      #1_000_000;
      error_cnt++;
      $display("MISMATCH watchdog exp done got hang");
      end_sim();
   end
   // ======
   // tests
   initial begin
      {presetn, psel, penable, pwrite, sleep} = 5'h0;
      paddr = 12'h000;
      pwdata = 32'h0;
      repeat (3) @(posedge pclk);
      presetn <= 1'b1;
      for (int i = 0; i < 3; i++) begin
         rdchk(12'(16 * i), 32'h0);
         rdchk(12'(16 * i + 4), 32'hff);
         rdchk(12'(16 * i + 8), 32'h0);
      end
      for (int a = 'h30; a < 'h3c; a += 4) rdchk(12'(a), 32'h0);
      apb(1'b0, 12'h03c, 32'h0);
      chk("unmapped error", 32'h1, 32'(err));
      chk("unmapped data", 32'h0, rd);
      wr(12'h14, 32'h3);
      for (int p = 0; p < 4; p++) begin
         wr(12'h18, 32'(4 + p));
         meas(1, m);
         chk("match period", 32'(16 << (2 * p)), 32'(m));
      end
      // stop the second timer so its flag cannot leak into later reads
      wr(12'h18, 32'h0);
      rdchk(12'h34, 32'h2);
      wr(12'h04, 32'h0);
      wr(12'h08, 32'h4);
      repeat (20) @(posedge pclk);
      chk("masked irq", 32'h0, 32'(irq));
      wr(12'h08, 32'h0);
      rdchk(12'h34, 32'h1);
      rdchk(12'h34, 32'h0);
      wr(12'h38, 32'h1);
      for (int k = 0; k < 16; k += 5) begin
         wr(12'h08, 32'((k << 3) + 4));
         m = 0;
         while (irq !== 1'b1) begin
            @(posedge pclk);
            if (timer_match[0] === 1'b1) m++;
         end
         chk("postscale", 32'(k + 1), 32'(m));
         wr(12'h08, 32'h0);
         rdchk(12'h34, 32'h1);
         repeat (2) @(posedge pclk);
         chk("cleared irq", 32'h0, 32'(irq));
      end
      // first timer keeps matching every 4 cycles unless asleep
      wr(12'h08, 32'h4);
      wr(12'h24, 32'hff);
      wr(12'h28, 32'h4);
      repeat (40) @(posedge pclk);
      sleep <= 1'b1;
      apb(1'b0, 12'h020, 32'h0);
      v = rd;
      repeat (40) @(posedge pclk);
      rdchk(12'h020, v);
      rdchk(12'h024, 32'hff);
      sleep <= 1'b0;
      // stop first, so no tick lands between the load and the stop
      wr(12'h28, 32'h80);
      wr(12'h20, 32'h42);
      wr(12'h28, 32'h80);
      rdchk(12'h28, 32'h0);
      repeat (40) @(posedge pclk);
      rdchk(12'h20, 32'h42);
      wr(12'h18, 32'h4);
      foreach (sel_v[j]) begin
         wr(12'h30, 32'(sel_v[j]));
         rdchk(12'h30, 32'(sel_v[j]));
         @(negedge pclk);
         up0 = unit_pulses;
         mt = '{0, 0, 0};
         repeat (200) begin
            @(posedge pclk);
            for (int t = 0; t < 3; t++) begin
               if (timer_match[t] === 1'b1) mt[t]++;
            end
         end
         @(negedge pclk);
         for (int u = 0; u < 4; u++) begin
            c = (sel_v[j] >> (2 * u)) & 8'h3;
            v = (c == 8'h3) ? 32'h0 : 32'(mt[c]);
            chk("unit", v, 32'(8'(unit_pulses[u] - up0[u])));
         end
      end
      // let the last toggle reach the serial side model
      wr(12'h08, 32'h0);
      repeat (3) @(posedge pclk);
      chk("shift edges", 32'(m0_total), 32'(spi_edges));
      end_sim();
   end
endmodule : prtm_top_bench
